// ---- hplw_params.svh ----
// Constants for the host port latch and write block
`ifndef HPLW_PARAMS_SVH
`define HPLW_PARAMS_SVH
`define HPLW_BUS_WIDTH        16
`define HPLW_MEM_ADDR_WIDTH   14
`define HPLW_CLK_PERIOD_PS    10000
`define HPLW_ACK_LOW_MIN_PS   15000
`define HPLW_ACK_LOW_MIN_CYC  ((`HPLW_ACK_LOW_MIN_PS + `HPLW_CLK_PERIOD_PS - 1) / `HPLW_CLK_PERIOD_PS)
`define HPLW_ADDR_RESET       16'h0000
`define HPLW_ACK_RESET        1'b0
`endif

// ---- hplw_pkg.sv ----
// Types for the host port latch and write block
package hplw_pkg;
  typedef enum logic [1:0] {
    HPLW_IDLE    = 2'b00,
    HPLW_LATCH   = 2'b01,
    HPLW_WRITE   = 2'b10,
    HPLW_READ    = 2'b11
  } hplw_state_t;

  typedef struct packed {
    logic        select_n;
    logic        latch;
    logic        write_n;
    logic        read_n;
    logic [15:0] bus;
  } hplw_pins_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] addr;
    logic [15:0] data;
  } hplw_mem_write_t;
endpackage

// ---- hplw_host_port.sv ----
// Address latch and write side of the internal memory host port
//
// Summary of operation
// - Latch phase starts when select is low and latch strobe is high.
// - Latch phase ends when select rises or latch strobe falls.
// - Bus value at latch end is captured as the transfer address.
// - Access starts when select is low with write or read strobe low.
// - Write ends when select or write strobe rises; data word taken then.
// - Acknowledge goes high once a write starts, showing the port is busy.
// - Acknowledge returns low no sooner than 1.5 clock periods after write start.
// - Strobe ending before acknowledge low is short write, after is long write.
`timescale 1ns/1ns
`include "hplw_params.svh"

module hplw_host_port #(
  parameter int ADDR_WIDTH = `HPLW_MEM_ADDR_WIDTH
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // Host pins
  input  wire logic                      host_port_select_n,
  input  wire logic                      host_address_latch_strobe,
  input  wire logic                      host_write_strobe_n,
  input  wire logic                      host_read_strobe_n,
  input  wire logic [`HPLW_BUS_WIDTH-1:0] host_addr_data_bus,
  output logic                           host_port_acknowledge_n,
  // Internal memory write port
  output hplw_pkg::hplw_mem_write_t      mem_write,
  // Status
  output logic                           long_write,
  output logic                           read_start
);

  initial begin
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > `HPLW_BUS_WIDTH) begin
      $error("ADDR_WIDTH out of range");
    end
  end

  localparam logic [3:0] ACK_CYC = 4'(`HPLW_ACK_LOW_MIN_CYC);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  hplw_pkg::hplw_pins_t pins_meta;
  hplw_pkg::hplw_pins_t pins;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pins_meta <= '{select_n: 1'b1, latch: 1'b0, write_n: 1'b1, read_n: 1'b1, bus: 16'h0000};
      pins      <= '{select_n: 1'b1, latch: 1'b0, write_n: 1'b1, read_n: 1'b1, bus: 16'h0000};
    end else begin
      pins_meta <= '{select_n: host_port_select_n, latch: host_address_latch_strobe,
                     write_n: host_write_strobe_n, read_n: host_read_strobe_n, bus: host_addr_data_bus};
      pins      <= pins_meta;
    end
  end

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  logic latch_on;
  logic write_on;
  logic read_on;
  assign latch_on = !pins.select_n && pins.latch;
  assign write_on = !pins.select_n && !pins.write_n;
  assign read_on  = !pins.select_n && !pins.read_n;

  hplw_pkg::hplw_state_t state;
  logic [ADDR_WIDTH-1:0] addr;
  logic [3:0]            ack_cnt;
  logic                  latch_end;
  logic                  write_end;
  logic                  write_start;
  logic                  ack_seen_meta;
  logic                  ack_seen;

  // ----------------------------------------
  // Phase end decode
  // ----------------------------------------
  // True in the cycle a phase is seen to have ended
  function automatic logic phase_done(
    input hplw_pkg::hplw_state_t cur,
    input hplw_pkg::hplw_state_t want,
    input logic                  still_on
  );
    phase_done = (cur == want) && !still_on;
  endfunction

  assign latch_end   = phase_done(state, hplw_pkg::HPLW_LATCH, latch_on);
  assign write_end   = phase_done(state, hplw_pkg::HPLW_WRITE, write_on);
  assign write_start = state == hplw_pkg::HPLW_IDLE && !latch_on && write_on;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= hplw_pkg::HPLW_IDLE;
    end else begin
      unique case (state)
        hplw_pkg::HPLW_IDLE: begin
          if (latch_on) begin
            state <= hplw_pkg::HPLW_LATCH;
          end else if (write_on) begin
            state <= hplw_pkg::HPLW_WRITE;
          end else if (read_on) begin
            state <= hplw_pkg::HPLW_READ;
          end
        end
        hplw_pkg::HPLW_LATCH: begin
          if (!latch_on) begin
            state <= hplw_pkg::HPLW_IDLE;
          end
        end
        hplw_pkg::HPLW_WRITE: begin
          if (!write_on) begin
            state <= hplw_pkg::HPLW_IDLE;
          end
        end
        hplw_pkg::HPLW_READ: begin
          if (!read_on) begin
            state <= hplw_pkg::HPLW_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Address latch and advance
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr <= ADDR_WIDTH'(`HPLW_ADDR_RESET);
    end else if (latch_end) begin
      addr <= pins.bus[ADDR_WIDTH-1:0];
    end else if (write_end) begin
      addr <= addr + ADDR_WIDTH'(1);
    end
  end

  // ----------------------------------------
  // Acknowledge count
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_cnt <= 4'h0;
    end else if (write_start) begin
      ack_cnt <= 4'h1;
    end else if (host_port_acknowledge_n && ack_cnt < ACK_CYC) begin
      ack_cnt <= ack_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Acknowledge line
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_port_acknowledge_n <= `HPLW_ACK_RESET;
    end else if (write_start) begin
      host_port_acknowledge_n <= 1'b1;
    end else if (host_port_acknowledge_n && ack_cnt >= ACK_CYC) begin
      host_port_acknowledge_n <= 1'b0;
    end
  end

  // ----------------------------------------
  // Acknowledge history
  // ----------------------------------------
  // Delays ack by the synchroniser depth so a strobe end is judged
  // against the ack level the host saw when it let go
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_seen_meta <= `HPLW_ACK_RESET;
      ack_seen      <= `HPLW_ACK_RESET;
    end else begin
      ack_seen_meta <= host_port_acknowledge_n;
      ack_seen      <= ack_seen_meta;
    end
  end

  // ----------------------------------------
  // Memory write
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_write <= '0;
    end else begin
      mem_write.valid <= 1'b0;
      if (write_end) begin
        mem_write.valid <= 1'b1;
        mem_write.addr  <= 14'(addr);
        mem_write.data  <= pins.bus;
      end
    end
  end

  // ----------------------------------------
  // Write kind
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      long_write <= 1'b0;
    end else if (write_end) begin
      long_write <= !ack_seen;
    end
  end

  // ----------------------------------------
  // Read start
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      read_start <= 1'b0;
    end else begin
      read_start <= state == hplw_pkg::HPLW_IDLE && !latch_on && !write_on && read_on;
    end
  end

endmodule

// ---- hplw_host_port_chk.sv ----
// Checker for the host port latch and write block
`timescale 1ns/1ns
module hplw_host_port_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host pins
  input wire logic host_port_select_n,
  input wire logic host_address_latch_strobe,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic host_port_acknowledge_n,
  // Core side
  input wire hplw_pkg::hplw_mem_write_t mem_write,
  input wire logic read_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_ws; $fell(host_write_strobe_n) && !host_port_select_n; endsequence
  sequence s_we; $rose(host_write_strobe_n) && !host_port_select_n; endsequence
  property p_ack; s_ws |-> ##[1:5] host_port_acknowledge_n; endproperty
  a_ack: assert property (p_ack) else $error("ack not raised");
  property p_cause; $rose(host_port_acknowledge_n) |-> !$past(host_write_strobe_n); endproperty
  a_cause: assert property (p_cause) else $error("ack without write");
  property p_min; $rose(host_port_acknowledge_n) |-> host_port_acknowledge_n[*2]; endproperty
  a_min: assert property (p_min) else $error("ack low too soon");
  property p_store; s_we |-> ##[1:5] mem_write.valid; endproperty
  a_store: assert property (p_store) else $error("word not stored");
  property p_end; mem_write.valid |-> host_write_strobe_n && $past(host_write_strobe_n); endproperty
  a_end: assert property (p_end) else $error("stored before end");
  property p_pulse; mem_write.valid |=> !mem_write.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("store too long");
  property p_rd; read_start |-> !$past(host_read_strobe_n) ##1 !read_start; endproperty
  a_rd: assert property (p_rd) else $error("bad read start");
  property p_latch;
    host_address_latch_strobe && !host_port_select_n |-> !host_port_acknowledge_n && !mem_write.valid;
  endproperty
  a_latch: assert property (p_latch) else $error("access during latch");
endmodule
bind hplw_host_port hplw_host_port_chk i_chk (.*);

// ---- hplw_host_model.sv ----
// Host processor model for the host port
`timescale 1ns/1ns
module hplw_host_model (
  // Clock and device side
  input  wire logic            mclk,
  input  wire logic            ack_n,
  // Host pins
  output hplw_pkg::hplw_pins_t p,
  output logic                 late
);
  initial {p, late} = {4'hb, 16'h5a5a, 1'b0};
  task automatic go(input logic [19:0] v, input int n);
    p = v;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic ready;
    for (int k = 0; k < 40 && ack_n !== 1'b0; k++) go(p, 1);
    late = late | ack_n !== 1'b0;
  endtask
  task automatic latch(input logic [15:0] a, input logic s);
    ready;
    go({4'h7, a}, 4);
    go({s, s, 2'h3, a}, 1);
    go({4'hb, ~a}, 4);
  endtask
  task automatic write(input logic [15:0] d, input int n);
    ready;
    go({4'h1, d}, n);
    go({4'h3, d}, 1);
    go({4'hb, ~d}, 6);
  endtask
  task automatic read;
    ready;
    go({4'h2, p.bus}, 5);
    go({4'hb, p.bus}, 6);
  endtask
endmodule

// ---- hplw_host_port_tb.sv ----
// Testbench for the host port latch and write block
`timescale 1ns/1ns
module hplw_host_port_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ack_n, long_write, read_start, late;
  logic [30:0] got;
  hplw_pkg::hplw_pins_t p;
  hplw_pkg::hplw_mem_write_t mem_write;
  int n_fail = 0, tests_run = 0, n_got = 0, n_rd = 0;
  always #5 mclk = ~mclk;
  hplw_host_model i_hplw_host_model (.mclk(mclk), .ack_n(ack_n), .p(p), .late(late));
  hplw_host_port i_hplw_host_port (.mclk(mclk), .reset(reset), .host_port_select_n(p.select_n),
    .host_address_latch_strobe(p.latch), .host_write_strobe_n(p.write_n), .host_read_strobe_n(p.read_n),
    .host_addr_data_bus(p.bus), .host_port_acknowledge_n(ack_n), .mem_write(mem_write),
    .long_write(long_write), .read_start(read_start));
  always @(negedge mclk) begin
    if (mem_write.valid === 1'b1) begin
      got = {mem_write.addr, mem_write.data, long_write};
      n_got++;
    end
    if (read_start === 1'b1) n_rd++;
  end
  task automatic chk(input string w, input logic [38:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] d, input int n, input logic [13:0] a, input logic lg);
    int c;
    c = n_got;
    i_hplw_host_model.write(d, n);
    chk("write", {8'(c + 1), a, d, lg}, {8'(n_got), got});
  endtask
  task automatic t_burst; // One latch, writes run over the top of memory
    i_hplw_host_model.latch(16'hfffe, 1'b0);
    wr(16'ha5c3, 7, 14'h3ffe, 1'b1);
    wr(16'h0ff0, 3, 14'h3fff, 1'b0);
    wr(16'h1234, 7, 14'h0000, 1'b1);
  endtask
  task automatic t_relatch; // Latch ended by select
    i_hplw_host_model.latch(16'h4005, 1'b1);
    wr(16'h8001, 3, 14'h0005, 1'b0);
  endtask
  task automatic t_read; // Read gives one pulse and stores nothing
    int r, c;
    r = n_rd;
    c = n_got;
    i_hplw_host_model.read;
    chk("read", {8'(r + 1), 8'(c)}, {8'(n_rd), 8'(n_got)});
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    chk("ack", 39'h0, {38'h0, ack_n});
    t_burst;
    t_relatch;
    t_read;
    chk("late", 39'h0, {38'h0, late});
    complete_run;
  end
endmodule
